//--- bench/tb.sv
// self-checking bench for the uart line status flag block
// assumes the host model as bus master and a short frame length
`timescale 1ns/10ps
module tb;
	import ulsf_pkg::*;
	localparam int FB = 3;
	localparam logic [4:0] E_HW = 5'h01;
	localparam logic [4:0] E_LD = 5'h02;
	localparam logic [4:0] E_RR = 5'h04;
	localparam logic [4:0] E_TK = 5'h08;
	localparam logic [4:0] E_CD = 5'h10;
	localparam logic [31:0] ES = 32'h1 << ULSF_BIT_ERR_SUM;
	localparam logic [31:0] TE = 32'h1 << ULSF_BIT_TX_EMPTY;
	localparam logic [31:0] HE = 32'h1 << ULSF_BIT_HOLD_EMPTY;
	localparam logic [31:0] BK = 32'h1 << ULSF_BIT_BREAK;
	localparam logic [31:0] FR = 32'h1 << ULSF_BIT_FRAMING;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] ev = 5'h00;
	logic busy = 1'b0;
	logic fifo_empty = 1'b1;
	logic rx_serial = 1'b1;
	logic stop_ok = 1'b1;
	logic char_err = 1'b0;
	logic has_err = 1'b0;
	logic ce = 1'b1;
	logic head_fr = 1'b0;
	logic [3:0] addr;
	logic [3:0] be;
	logic rd;
	logic wr;
	logic wait_req;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] r;
	logic [7:0] ls;
	logic push;
	logic irq;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int pushes = 0;

	ulsf_host_model host (.sys_clk_i(sys_clk), .avs_address_o(addr), .avs_read_o(rd),
		.avs_write_o(wr), .avs_writedata_o(wdata), .avs_byteenable_o(be),
		.avs_readdata_i(rdata), .avs_waitrequest_i(wait_req));
	ulsf_line_status #(.FRAME_BITS(FB)) dut (.sys_clk_i(sys_clk), .reset_i(reset), .ce_i(ce),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.tx_holding_write_i(ev[0]), .tx_shift_load_i(ev[1]), .tx_shift_busy_i(busy),
		.tx_fifo_empty_i(fifo_empty), .rx_holding_read_i(ev[2]), .rx_serial_i(rx_serial),
		.baud_bit_tick_i(ev[3]), .rx_char_done_i(ev[4]), .rx_stop_ok_i(stop_ok),
		.rx_char_error_i(char_err), .rx_fifo_has_error_i(has_err),
		.rx_head_framing_i(head_fr), .line_status_reg_o(ls), .rx_break_push_o(push), .irq_o(irq));

	always #2 sys_clk = ~sys_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	always @(posedge sys_clk) begin
		cyc++;
		if (push === 1'b1) pushes++;
		if (cyc == 3000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle event strobe, flags checked once it has landed
	task automatic pulse(input logic [4:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 5'h00;
		#1;
	endtask : pulse

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		#1 chk({24'h0, ls}, TE | HE);
		chk({31'h0, irq}, 32'h0);
		host.bus_read(ULSF_OFS_IRQ_MASK, r);
		chk(r, 32'h0);
	endtask : t_reset

	task automatic t_tx_plain();
		host.bus_write(ULSF_OFS_CONTROL, 32'h1 << ULSF_CTL_HOLD_IRQ_EN);
		#1 chk({31'h0, irq}, 32'h1);
		pulse(E_HW);
		chk({24'h0, ls}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		host.bus_read(ULSF_OFS_LINE_STATUS, r);
		chk(r, 32'h0);
		@(posedge sys_clk);
		busy <= 1'b1;
		pulse(E_LD);
		chk({24'h0, ls}, HE);
		chk({31'h0, irq}, 32'h1);
		@(posedge sys_clk);
		busy <= 1'b0;
		#1 chk({24'h0, ls}, TE | HE);
		// a holding write while frozen must leave the flags alone
		@(posedge sys_clk);
		ce <= 1'b0;
		pulse(E_HW);
		chk({24'h0, ls}, TE | HE);
		@(posedge sys_clk);
		ce <= 1'b1;
	endtask : t_tx_plain

	task automatic t_framing();
		@(posedge sys_clk);
		stop_ok <= 1'b0;
		pulse(E_CD);
		chk({24'h0, ls} & FR, FR);
		host.bus_read(ULSF_OFS_LINE_STATUS, r);
		chk(r & FR, FR);
		#1 chk({24'h0, ls} & FR, 32'h0);
		pulse(E_RR);
		chk({24'h0, ls} & ES, 32'h0);
	endtask : t_framing

	task automatic t_fifo_tx();
		host.bus_write(ULSF_OFS_CONTROL, 32'h1 << ULSF_CTL_FIFO_MODE);
		@(posedge sys_clk);
		stop_ok <= 1'b1;
		fifo_empty <= 1'b0;
		pulse(E_HW);
		chk({24'h0, ls}, 32'h0);
		@(posedge sys_clk);
		fifo_empty <= 1'b1;
		busy <= 1'b1;
		@(posedge sys_clk);
		#1 chk({24'h0, ls}, HE);
		@(posedge sys_clk);
		busy <= 1'b0;
		#1 chk({24'h0, ls}, TE | HE);
		@(posedge sys_clk);
		head_fr <= 1'b1;
		@(posedge sys_clk);
		#1 chk({24'h0, ls} & FR, FR);
		@(posedge sys_clk);
		head_fr <= 1'b0;
		@(posedge sys_clk);
		#1 chk({24'h0, ls} & FR, 32'h0);
	endtask : t_fifo_tx

	task automatic t_error();
		@(posedge sys_clk);
		char_err <= 1'b1;
		has_err <= 1'b1;
		pulse(E_CD);
		chk({24'h0, ls} & ES, ES);
		@(posedge sys_clk);
		char_err <= 1'b0;
		has_err <= 1'b0;
		pulse(E_RR);
		chk({24'h0, ls} & ES, 32'h0);
	endtask : t_error

	task automatic t_break();
		host.bus_write(ULSF_OFS_IRQ_MASK, 32'h1 << ULSF_IRQ_BREAK);
		@(posedge sys_clk);
		rx_serial <= 1'b0;
		repeat (FB - 1) pulse(E_TK);
		@(posedge sys_clk);
		#1 chk({24'h0, ls} & BK, 32'h0);
		pulse(E_TK);
		@(posedge sys_clk);
		#1 chk({24'h0, ls} & BK, BK);
		chk({31'h0, irq}, 32'h1);
		repeat (4) pulse(E_TK);
		chk(32'(pushes), 32'h1);
		@(posedge sys_clk);
		rx_serial <= 1'b1;
		host.bus_read(ULSF_OFS_IRQ_STATUS, r);
		chk(r & (32'h1 << ULSF_IRQ_BREAK), 32'h1 << ULSF_IRQ_BREAK);
		#1 chk({31'h0, irq}, 32'h0);
		host.bus_read(ULSF_OFS_LINE_STATUS, r);
		chk(r & BK, BK);
		#1 chk({24'h0, ls} & BK, 32'h0);
		// unmapped place reads zero and ignores writes
		host.bus_write(4'h2, 32'hFF);
		host.bus_read(4'h2, r);
		chk(r, 32'h0);
	endtask : t_break

	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset();
		t_tx_plain();
		t_framing();
		t_fifo_tx();
		t_error();
		t_break();
		conclude();
	end
endmodule : tb

//--- bench/ulsf_host_model.sv
// host processor model: avalon-mm master for the line status block
// assumes one clock; the bench timeout ends any wait that never completes
`timescale 1ns/10ps
module ulsf_host_model (
	input wire logic sys_clk_i,
	output logic [3:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	output logic [3:0] avs_byteenable_o,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i
);
	initial begin
		avs_address_o = 4'h0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0;
		avs_byteenable_o = 4'hF;
	end

	// request held until the edge that samples waitrequest low
	task automatic bus_write(input logic [3:0] addr, input logic [31:0] data);
		@(posedge sys_clk_i);
		avs_address_o <= addr;
		avs_writedata_o <= data;
		avs_write_o <= 1'b1;
		@(posedge sys_clk_i);
		while (avs_waitrequest_i !== 1'b0) @(posedge sys_clk_i);
		avs_write_o <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [3:0] addr, output logic [31:0] data);
		@(posedge sys_clk_i);
		avs_address_o <= addr;
		avs_read_o <= 1'b1;
		@(posedge sys_clk_i);
		while (avs_waitrequest_i !== 1'b0) @(posedge sys_clk_i);
		data = avs_readdata_i;
		avs_read_o <= 1'b0;
	endtask : bus_read
endmodule : ulsf_host_model

//--- hw/ulsf_line_status.sv
// line status flag logic of one uart channel, avalon-mm slave with waitrequest
// assumes the transmit and receive datapaths report occupancy and events
// synchronously to sys_clk_i, and baud_bit_tick_i pulses once per bit time
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module ulsf_line_status #(
	parameter int FRAME_BITS = ulsf_pkg::ULSF_FRAME_BITS
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic tx_holding_write_i,
	input wire logic tx_shift_load_i,
	input wire logic tx_shift_busy_i,
	input wire logic tx_fifo_empty_i,
	input wire logic rx_holding_read_i,
	input wire logic rx_serial_i,
	input wire logic baud_bit_tick_i,
	input wire logic rx_char_done_i,
	input wire logic rx_stop_ok_i,
	input wire logic rx_char_error_i,
	input wire logic rx_fifo_has_error_i,
	input wire logic rx_head_framing_i,
	output logic [7:0] line_status_reg_o,
	output logic rx_break_push_o,
	output logic irq_o
);
	import ulsf_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic holding_empty;
		logic break_flag;
		logic framing_error_flag;
		logic fifo_error_summary_flag;
		logic [ULSF_CNT_W-1:0] low_bits;
		logic break_armed;
		logic break_push;
		logic [1:0] control;
		logic [ULSF_IRQ_W-1:0] irq_status;
		logic [ULSF_IRQ_W-1:0] irq_mask;
		logic ack;
		logic [31:0] rdata;
	} ulsf_state_t;

	localparam logic [ULSF_CNT_W-1:0] FRAME_CNT = ULSF_CNT_W'(FRAME_BITS);

	ulsf_state_t st;
	ulsf_state_t next_st;
	logic fifo_mode;
	logic hold_irq_en;
	logic tx_empty;
	logic access;
	logic acc_read;
	logic acc_write;
	logic read_line_status;
	logic read_irq_status;
	logic break_event;
	logic framing_event;
	logic hold_set;
	logic err_set;
	logic [7:0] line_status;

	assign fifo_mode = st.control[ULSF_CTL_FIFO_MODE];
	assign hold_irq_en = st.control[ULSF_CTL_HOLD_IRQ_EN];
	assign access = avs_read_i | avs_write_i;
	// read-clear acts at the capture edge, so an event landing in the wait
	// cycle stays set for the next read instead of being lost unseen
	assign acc_read = avs_read_i & ~st.ack & ce_i;
	assign acc_write = avs_write_i & st.ack & ce_i;
	assign read_line_status = acc_read & (avs_address_i == ULSF_OFS_LINE_STATUS);
	assign read_irq_status = acc_read & (avs_address_i == ULSF_OFS_IRQ_STATUS);

	// ----------------------------------------
	// transmit path flags
	// ----------------------------------------
	// transmitter empty
	// the holding stage (or fifo) is empty only when its flag is up
	assign tx_empty = st.holding_empty & ~tx_shift_busy_i;
	assign hold_set = fifo_mode ? tx_fifo_empty_i : tx_shift_load_i;

	// ----------------------------------------
	// receive path events
	// ----------------------------------------
	// full frame of low on the line
	assign break_event = st.break_armed & ~rx_serial_i & baud_bit_tick_i
		& (st.low_bits == FRAME_CNT - 1'b1);
	// stop bit missing on a completed character
	assign framing_event = rx_char_done_i & ~rx_stop_ok_i;
	// any flagged character reaching the receive path
	assign err_set = (fifo_mode & rx_fifo_has_error_i) | break_event | framing_event
		| (rx_char_done_i & rx_char_error_i);

	always_comb begin
		line_status = 8'h00;
		line_status[ULSF_BIT_ERR_SUM] = st.fifo_error_summary_flag;
		line_status[ULSF_BIT_TX_EMPTY] = tx_empty;
		line_status[ULSF_BIT_HOLD_EMPTY] = st.holding_empty;
		line_status[ULSF_BIT_BREAK] = st.break_flag;
		line_status[ULSF_BIT_FRAMING] = st.framing_error_flag;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.break_push = 1'b0;
		next_st.ack = 1'b0;
		if (ce_i) begin
			// host write clears, a simultaneous set loses to the write
			// since the new character is occupying the holding stage
			if (tx_holding_write_i) begin
				next_st.holding_empty = 1'b0;
			end else if (hold_set) begin
				next_st.holding_empty = 1'b1;
			end
			// status read touches no transmit flag
			// count bit times of low, rearm only on a high line
			if (rx_serial_i) begin
				next_st.low_bits = '0;
				next_st.break_armed = 1'b1;
			end else if (baud_bit_tick_i && st.break_armed) begin
				next_st.low_bits = st.low_bits + 1'b1;
				if (break_event) begin
					next_st.break_armed = 1'b0;
					next_st.break_push = fifo_mode;
					next_st.low_bits = '0;
				end
			end
			// break flag sticky until status read, set wins
			if (break_event) begin
				next_st.break_flag = 1'b1;
			end else if (read_line_status) begin
				next_st.break_flag = 1'b0;
			end
			// framing error: head entry in fifo mode, sticky otherwise
			if (fifo_mode) begin
				next_st.framing_error_flag = rx_head_framing_i;
			end else if (framing_event) begin
				next_st.framing_error_flag = 1'b1;
			end else if (read_line_status) begin
				next_st.framing_error_flag = 1'b0;
			end
			// error summary set wins over receive holding read
			if (err_set) begin
				next_st.fifo_error_summary_flag = 1'b1;
			end else if (rx_holding_read_i) begin
				next_st.fifo_error_summary_flag = 1'b0;
			end
			// interrupt status, read clears, set wins
			if (read_irq_status) begin
				next_st.irq_status = '0;
			end
			if (hold_set && !st.holding_empty && !tx_holding_write_i) begin
				next_st.irq_status[ULSF_IRQ_HOLD] = 1'b1;
			end
			if (break_event) begin
				next_st.irq_status[ULSF_IRQ_BREAK] = 1'b1;
			end
			if (framing_event) begin
				next_st.irq_status[ULSF_IRQ_FRAMING] = 1'b1;
			end
			if (err_set) begin
				next_st.irq_status[ULSF_IRQ_ERR_SUM] = 1'b1;
			end
			// bus: one wait cycle, then the access completes on ack
			next_st.ack = access & ~st.ack;
			if (access && !st.ack) begin
				next_st.rdata = 32'h0000_0000;
				if (avs_read_i) begin
					unique case (avs_address_i)
						ULSF_OFS_LINE_STATUS: next_st.rdata[7:0] = line_status;
						ULSF_OFS_CONTROL: next_st.rdata[1:0] = st.control;
						ULSF_OFS_IRQ_STATUS: next_st.rdata[ULSF_IRQ_W-1:0] = st.irq_status;
						ULSF_OFS_IRQ_MASK: next_st.rdata[ULSF_IRQ_W-1:0] = st.irq_mask;
						default: next_st.rdata = 32'h0000_0000;
					endcase
				end
			end
			if (acc_write && avs_byteenable_i[0]) begin
				unique case (avs_address_i)
					ULSF_OFS_CONTROL: next_st.control = avs_writedata_i[1:0];
					ULSF_OFS_IRQ_MASK: next_st.irq_mask = avs_writedata_i[ULSF_IRQ_W-1:0];
					default: next_st.control = st.control;
				endcase
			end
		end else begin
			next_st.break_push = st.break_push;
			next_st.ack = st.ack;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			// error, break and framing flags start clear
			st <= '{holding_empty: 1'b1, break_flag: 1'b0, framing_error_flag: 1'b0,
				fifo_error_summary_flag: 1'b0, low_bits: '0, break_armed: 1'b0,
				break_push: 1'b0, control: ULSF_CONTROL_RST, irq_status: '0,
				irq_mask: ULSF_IRQ_MASK_RST, ack: 1'b0, rdata: 32'h0000_0000};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_readdata_o = st.rdata;
	// waitrequest also stays high while frozen, so nothing completes then
	assign avs_waitrequest_o = access & ~(st.ack & ce_i);
	assign line_status_reg_o = line_status;
	assign rx_break_push_o = st.break_push & ce_i;
	// holding empty interrupt plus masked sticky events
	assign irq_o = (st.holding_empty & hold_irq_en) | (|(st.irq_status & st.irq_mask));

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	a_hold_clear_write: assert property (
		ce_i && tx_holding_write_i |=> !line_status_reg_o[ULSF_BIT_HOLD_EMPTY])
		else $error("holding empty not cleared by write");
	a_hold_set_load: assert property (
		ce_i && !fifo_mode && tx_shift_load_i && !tx_holding_write_i
		|=> line_status_reg_o[ULSF_BIT_HOLD_EMPTY])
		else $error("holding empty not set on shifter load");
	a_fifo_hold_empty: assert property (
		ce_i && fifo_mode && tx_fifo_empty_i && !tx_holding_write_i
		|=> line_status_reg_o[ULSF_BIT_HOLD_EMPTY])
		else $error("holding empty not set on empty fifo");
	a_tx_empty_busy: assert property (
		tx_shift_busy_i || !line_status_reg_o[ULSF_BIT_HOLD_EMPTY]
		|-> !line_status_reg_o[ULSF_BIT_TX_EMPTY])
		else $error("transmitter empty while data held");
	a_tx_empty_idle: assert property (
		!tx_shift_busy_i && line_status_reg_o[ULSF_BIT_HOLD_EMPTY]
		|-> line_status_reg_o[ULSF_BIT_TX_EMPTY])
		else $error("transmitter empty missing");
	a_irq_hold: assert property (
		line_status_reg_o[ULSF_BIT_HOLD_EMPTY] && hold_irq_en |-> irq_o)
		else $error("holding empty interrupt missing");
	a_err_sum_clear: assert property (
		ce_i && rx_holding_read_i && !err_set |=> !line_status_reg_o[ULSF_BIT_ERR_SUM])
		else $error("error summary not cleared by holding read");
	a_err_sum_set: assert property (
		ce_i && fifo_mode && rx_fifo_has_error_i |=> line_status_reg_o[ULSF_BIT_ERR_SUM])
		else $error("error summary not set");
	a_break_once: assert property (
		!st.break_armed && !rx_serial_i |=> !break_event)
		else $error("second break in one low period");
	a_break_flag: assert property (
		ce_i && break_event |=> line_status_reg_o[ULSF_BIT_BREAK])
		else $error("break flag not set");
	a_framing_set: assert property (
		ce_i && !fifo_mode && framing_event |=> line_status_reg_o[ULSF_BIT_FRAMING])
		else $error("framing error not set");
	a_status_read_tx: assert property (
		read_line_status && !tx_holding_write_i && !hold_set
		|=> $stable(line_status_reg_o[ULSF_BIT_HOLD_EMPTY]))
		else $error("status read changed holding empty");
	a_flags_quiet: assert property (
		$fell(reset_i) |-> !line_status_reg_o[ULSF_BIT_ERR_SUM]
		&& !line_status_reg_o[ULSF_BIT_BREAK] && !line_status_reg_o[ULSF_BIT_FRAMING])
		else $error("error flags set after reset");
	a_bus_wait: assert property (
		ce_i && access && !st.ack |=> !avs_waitrequest_o || !ce_i)
		else $error("bus access not answered in one cycle");

	// ----------------------------------------
	// receive path checks
	// ----------------------------------------
	a_break_push_fifo: assert property (
		ce_i && fifo_mode && break_event |=> rx_break_push_o || !ce_i)
		else $error("break character not pushed");
	a_push_pulse: assert property (
		rx_break_push_o |=> !rx_break_push_o)
		else $error("break push longer than one cycle");
	a_break_irq: assert property (
		ce_i && break_event |=> st.irq_status[ULSF_IRQ_BREAK])
		else $error("break interrupt status not set");
	a_break_clear: assert property (
		read_line_status && !break_event |=> !line_status_reg_o[ULSF_BIT_BREAK])
		else $error("break flag not cleared by status read");
	a_framing_fifo: assert property (
		ce_i && fifo_mode
		|=> line_status_reg_o[ULSF_BIT_FRAMING] == $past(rx_head_framing_i))
		else $error("framing flag not following fifo head");
	a_framing_clear: assert property (
		!fifo_mode && read_line_status && !framing_event
		|=> !line_status_reg_o[ULSF_BIT_FRAMING])
		else $error("framing flag not cleared by status read");
	a_err_char: assert property (
		ce_i && rx_char_done_i && rx_char_error_i |=> line_status_reg_o[ULSF_BIT_ERR_SUM])
		else $error("error summary missed a flagged character");

	// ----------------------------------------
	// register bus checks
	// ----------------------------------------
	a_ctl_write: assert property (
		acc_write && avs_byteenable_i[0] && (avs_address_i == ULSF_OFS_CONTROL)
		|=> {30'h0, st.control} == ($past(avs_writedata_i) & 32'h0000_0003))
		else $error("control write not stored");
	a_rdata_status: assert property (
		ce_i && avs_read_i && !st.ack && (avs_address_i == ULSF_OFS_LINE_STATUS)
		|=> avs_readdata_o == {24'h00_0000, $past(line_status_reg_o)})
		else $error("line status read data wrong");

	c_break_seen: cover property (rx_break_push_o);
	c_framing_head: cover property (fifo_mode && line_status_reg_o[ULSF_BIT_FRAMING]);
	c_hold_irq: cover property ($rose(irq_o));
	c_status_read: cover property (read_line_status);
	c_err_cleared: cover property ($fell(line_status_reg_o[ULSF_BIT_ERR_SUM]));

endmodule : ulsf_line_status

//--- hw/ulsf_pkg.sv
// constants for the uart line status flag block
// assumes one 250 MHz clock domain and a 32-bit avalon-mm register bus
package ulsf_pkg;

	// ----------------------------------------
	// register map (word aligned byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ULSF_OFS_LINE_STATUS = 4'h0;
	localparam logic [3:0] ULSF_OFS_CONTROL = 4'h4;
	localparam logic [3:0] ULSF_OFS_IRQ_STATUS = 4'h8;
	localparam logic [3:0] ULSF_OFS_IRQ_MASK = 4'hC;

	// ----------------------------------------
	// line status bit positions
	// ----------------------------------------
	localparam int ULSF_BIT_ERR_SUM = 7;
	localparam int ULSF_BIT_TX_EMPTY = 6;
	localparam int ULSF_BIT_HOLD_EMPTY = 5;
	localparam int ULSF_BIT_BREAK = 4;
	localparam int ULSF_BIT_FRAMING = 3;

	// ----------------------------------------
	// control and interrupt fields
	// ----------------------------------------
	localparam int ULSF_CTL_FIFO_MODE = 0;
	localparam int ULSF_CTL_HOLD_IRQ_EN = 1;
	localparam int ULSF_IRQ_HOLD = 0;
	localparam int ULSF_IRQ_BREAK = 1;
	localparam int ULSF_IRQ_FRAMING = 2;
	localparam int ULSF_IRQ_ERR_SUM = 3;
	localparam int ULSF_IRQ_W = 4;

	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [1:0] ULSF_CONTROL_RST = 2'h0;
	localparam logic [3:0] ULSF_IRQ_MASK_RST = 4'h0;
	localparam int ULSF_FRAME_BITS = 10;
	localparam int ULSF_CNT_W = 5;

endpackage : ulsf_pkg
